// *** common/fari_pkg.sv ***
// constants shared by the flash access register front end
// Contract
// - user array is 124 pages of 512 bytes; page equals address divided by 512
// - data register at 0xBC holds byte to program and byte read back
// - byte address is high register 0xC7 above low register 0xC6
// - writing a command code to 0xB9 starts the matching array operation
// - all control, key, data and address registers are special function registers only
// - command, data, addresses reset 0x00; keys reset 0xFF; none bit addressable
// - codes: 1 program, 2 page erase, 3 erase all, 4 read, 8 protect; 5-7 reserved
// - command runs only with unlock key 0x3B; key cleared when operation ends
// - core stalls on the command write and interrupts wait until completion
// - read protection covers groups of four pages, one bit each
package fari_pkg;
  // register addresses in the special function space
  localparam logic [7:0] ADDR_COMMAND = 8'hB9;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hBA;
  localparam logic [7:0] ADDR_PROT_KEY = 8'hBB;
  localparam logic [7:0] ADDR_DATA = 8'hBC;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'hC6;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'hC7;
  // reset values
  localparam logic [7:0] RST_COMMAND = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_KEY = 8'hFF;
  // unlock key and unprogrammed protection key
  localparam logic [7:0] UNLOCK_VALUE = 8'h3B;
  localparam logic [7:0] KEY_BLANK = 8'hFF;
  // array organisation
  localparam int PAGE_COUNT = 124;
  localparam int PAGE_LSB = 9;
  localparam int GROUP_PAGES_LOG2 = 2;
  localparam int GROUP_COUNT = 31;
  // command codes written to the command register
  localparam logic [7:0] CMD_PROGRAM = 8'h01;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
  localparam logic [7:0] CMD_READ = 8'h04;
  localparam logic [7:0] CMD_PROTECT = 8'h08;
  // operation code presented to the array macro
  typedef enum logic [2:0] {
    FARI_OP_NONE,
    FARI_OP_PROGRAM,
    FARI_OP_ERASE_PAGE,
    FARI_OP_ERASE_ALL,
    FARI_OP_READ,
    FARI_OP_PROTECT
  } fari_op_t;
endpackage

// *** hw/fari_read_guard.sv ***
// read protection lookup: maps a byte address onto its four page group
`timescale 1ns/100ps
module fari_read_guard #(
  parameter int GROUPS = fari_pkg::GROUP_COUNT
) (
  // address under test
  input wire logic [15:0] addr_i,
  // one read protect bit per group, set means protected
  input wire logic [GROUPS-1:0] rd_prot_i,
  // results
  output logic [6:0] page_o,
  output logic page_ok_o,
  output logic rd_blocked_o
);
  logic [6:0] page;
  logic [4:0] group;

  // page is the address divided by 512, group is page divided by four
  assign page = addr_i[15:fari_pkg::PAGE_LSB];
  assign group = page[6:fari_pkg::GROUP_PAGES_LOG2];
  assign page_o = page;
  // pages above the user area hold firmware; page_ok_o keeps program, page erase and read out of them
  assign page_ok_o = (32'(page) < fari_pkg::PAGE_COUNT);
  assign rd_blocked_o = page_ok_o && rd_prot_i[group];
endmodule

// *** hw/fari_flash_regs.sv ***
// special function register front end and sequencer for the user flash array
`timescale 1ns/100ps
module fari_flash_regs #(
  parameter int GROUPS = fari_pkg::GROUP_COUNT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // special function register port from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // core control while an operation runs
  output logic core_stall_o,
  output logic irq_defer_o,
  // array macro port
  output logic flash_req_o,
  output fari_pkg::fari_op_t flash_op_o,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  input wire logic [7:0] flash_rdata_i,
  input wire logic flash_done_i,
  // protection configuration held in the array
  input wire logic [GROUPS-1:0] rd_prot_i,
  input wire logic [7:0] stored_prot_key_i
);
  typedef enum logic {
    FARI_IDLE,
    FARI_BUSY
  } fari_state_t;

  fari_state_t state_r, state_nxt;
  logic [7:0] command_r, unlock_key_r, prot_key_r, data_r, addr_lo_r, addr_hi_r;
  fari_pkg::fari_op_t op_r;
  logic [15:0] op_addr_r;
  logic [7:0] op_wdata_r;
  logic [15:0] byte_addr;
  logic page_ok, rd_blocked;
  logic wr_command, wr_unlock, wr_prot, wr_data, wr_lo, wr_hi;
  logic key_ok, prot_key_ok, cmd_allowed, start, finish;
  fari_pkg::fari_op_t cmd_op;
  // next values of every register but the sequencer state, built by continuous assignments below
  fari_pkg::fari_op_t op_nxt;
  logic [15:0] op_addr_nxt;
  logic [7:0] op_wdata_nxt;
  logic [7:0] command_nxt, unlock_key_nxt, prot_key_nxt, data_nxt, addr_lo_nxt, addr_hi_nxt;
  logic load_read;

  //////////////////////////////////////////////////////////////////////////////
  // one strobe test shared by all six writable registers
  function automatic logic strobe_for(input logic wr, input logic [7:0] addr,
                                      input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  // address decode; only the six special function addresses respond
  assign wr_command = strobe_for(sfr_wr_i, sfr_addr_i, fari_pkg::ADDR_COMMAND);
  assign wr_unlock = strobe_for(sfr_wr_i, sfr_addr_i, fari_pkg::ADDR_UNLOCK_KEY);
  assign wr_prot = strobe_for(sfr_wr_i, sfr_addr_i, fari_pkg::ADDR_PROT_KEY);
  assign wr_data = strobe_for(sfr_wr_i, sfr_addr_i, fari_pkg::ADDR_DATA);
  assign wr_lo = strobe_for(sfr_wr_i, sfr_addr_i, fari_pkg::ADDR_ADDR_LOW);
  assign wr_hi = strobe_for(sfr_wr_i, sfr_addr_i, fari_pkg::ADDR_ADDR_HIGH);

  // read mux; whole byte reads only, no bit addressing
  always_comb begin
    sfr_hit_o = 1'b1;
    unique case (sfr_addr_i)
      fari_pkg::ADDR_COMMAND: sfr_rdata_o = command_r;
      fari_pkg::ADDR_UNLOCK_KEY: sfr_rdata_o = unlock_key_r;
      fari_pkg::ADDR_PROT_KEY: sfr_rdata_o = prot_key_r;
      fari_pkg::ADDR_DATA: sfr_rdata_o = data_r;
      fari_pkg::ADDR_ADDR_LOW: sfr_rdata_o = addr_lo_r;
      fari_pkg::ADDR_ADDR_HIGH: sfr_rdata_o = addr_hi_r;
      default: begin
        sfr_rdata_o = 8'h00;
        sfr_hit_o = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // byte address and protection lookup
  assign byte_addr = {addr_hi_r, addr_lo_r};

  // only the verdicts of the guard are used; the page number itself is not needed here
  fari_read_guard #(
    .GROUPS(GROUPS)
  ) u_guard (
    .addr_i(byte_addr),
    .rd_prot_i(rd_prot_i),
    .page_o(),
    .page_ok_o(page_ok),
    .rd_blocked_o(rd_blocked)
  );

  // command decode; reserved and unknown codes map to no operation
  always_comb begin
    unique case (sfr_wdata_i)
      fari_pkg::CMD_PROGRAM: cmd_op = fari_pkg::FARI_OP_PROGRAM;
      fari_pkg::CMD_ERASE_PAGE: cmd_op = fari_pkg::FARI_OP_ERASE_PAGE;
      fari_pkg::CMD_ERASE_ALL: cmd_op = fari_pkg::FARI_OP_ERASE_ALL;
      fari_pkg::CMD_READ: cmd_op = fari_pkg::FARI_OP_READ;
      fari_pkg::CMD_PROTECT: cmd_op = fari_pkg::FARI_OP_PROTECT;
      default: cmd_op = fari_pkg::FARI_OP_NONE;
    endcase
  end

  // the key is checked as it stands when the command is written
  assign key_ok = (unlock_key_r == fari_pkg::UNLOCK_VALUE);
  // a blank stored protection key means the protection key is not compared
  assign prot_key_ok = (stored_prot_key_i == fari_pkg::KEY_BLANK) ||
                       (stored_prot_key_i == prot_key_r);

  // per command guards: byte and page commands need a user page
  always_comb begin
    unique case (cmd_op)
      fari_pkg::FARI_OP_PROGRAM: cmd_allowed = page_ok;
      fari_pkg::FARI_OP_ERASE_PAGE: cmd_allowed = page_ok;
      fari_pkg::FARI_OP_ERASE_ALL: cmd_allowed = 1'b1;
      fari_pkg::FARI_OP_READ: cmd_allowed = page_ok && !rd_blocked;
      fari_pkg::FARI_OP_PROTECT: cmd_allowed = prot_key_ok;
      default: cmd_allowed = 1'b0;
    endcase
  end

  // a wrong key drops the command before it reaches the array
  assign start = (state_r == FARI_IDLE) && wr_command && key_ok && cmd_allowed;
  // a done pulse while idle is ignored; it cannot end an operation never begun
  assign finish = (state_r == FARI_BUSY) && flash_done_i;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FARI_IDLE: if (start) state_nxt = FARI_BUSY;
      FARI_BUSY: if (flash_done_i) state_nxt = FARI_IDLE;
    endcase
  end

  // operation latch; the array sees a steady request until it answers
  assign op_nxt = start ? cmd_op : (finish ? fari_pkg::FARI_OP_NONE : op_r);
  assign op_addr_nxt = start ? byte_addr : op_addr_r;
  // protect setup sends the protection key, every other command the data byte
  assign op_wdata_nxt = !start ? op_wdata_r :
                        ((cmd_op == fari_pkg::FARI_OP_PROTECT) ? prot_key_r : data_r);

  // state and operation registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= FARI_IDLE;
      op_r <= fari_pkg::FARI_OP_NONE;
      op_addr_r <= 16'h0000;
      op_wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      op_addr_r <= op_addr_nxt;
      op_wdata_r <= op_wdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register next values; writes while busy cannot occur because the core is stalled
  // the command register keeps a refused code too, so software can read what it wrote
  assign command_nxt = wr_command ? sfr_wdata_i : command_r;
  // completion clears the key and wins over a same cycle write, forcing a fresh unlock
  assign unlock_key_nxt = finish ? fari_pkg::RST_KEY :
                          (wr_unlock ? sfr_wdata_i : unlock_key_r);
  assign prot_key_nxt = wr_prot ? sfr_wdata_i : prot_key_r;
  // read data lands only from a finished read and beats a same cycle data write
  assign load_read = finish && (op_r == fari_pkg::FARI_OP_READ);
  assign data_nxt = load_read ? flash_rdata_i :
                    (wr_data ? sfr_wdata_i : data_r);
  assign addr_lo_nxt = wr_lo ? sfr_wdata_i : addr_lo_r;
  assign addr_hi_nxt = wr_hi ? sfr_wdata_i : addr_hi_r;

  // command register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_r <= fari_pkg::RST_COMMAND;
    end else begin
      command_r <= command_nxt;
    end
  end

  // key registers; both come out of reset locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_key_r <= fari_pkg::RST_KEY;
      prot_key_r <= fari_pkg::RST_KEY;
    end else begin
      unlock_key_r <= unlock_key_nxt;
      prot_key_r <= prot_key_nxt;
    end
  end

  // data byte and the two halves of the byte address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_r <= fari_pkg::RST_DATA;
      addr_lo_r <= fari_pkg::RST_ADDR;
      addr_hi_r <= fari_pkg::RST_ADDR;
    end else begin
      data_r <= data_nxt;
      addr_lo_r <= addr_lo_nxt;
      addr_hi_r <= addr_hi_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs; the stall covers the write cycle itself so the core holds there
  assign core_stall_o = start || (state_r == FARI_BUSY);
  // interrupts wait out exactly the span in which the core is held
  assign irq_defer_o = core_stall_o;
  assign flash_req_o = (state_r == FARI_BUSY);
  assign flash_op_o = op_r;
  assign flash_addr_o = op_addr_r;
  assign flash_wdata_o = op_wdata_r;
endmodule

// *** testbench/fari_flash_regs_props.sv ***
// concurrent checks on the flash register front end ports
`timescale 1ns/100ps
module fari_flash_regs_props (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic core_stall_o,
  input wire logic irq_defer_o,
  input wire logic flash_req_o,
  input wire fari_pkg::fari_op_t flash_op_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic [7:0] flash_rdata_i,
  input wire logic flash_done_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_defer_same: assert property (irq_defer_o == core_stall_o)
    else $error("interrupt defer differs from stall");
  a_busy_stalls: assert property (flash_req_o |-> core_stall_o)
    else $error("core runs while array busy");
  a_start_write: assert property ($rose(flash_req_o) |-> $past(sfr_wr_i) &&
    $past(sfr_addr_i) == 8'hB9) else $error("request without command write");
  a_read_op: assert property ($rose(flash_req_o) && $past(sfr_wdata_i) == 8'h04
    |-> flash_op_o == fari_pkg::FARI_OP_READ) else $error("read code not mapped");
  a_req_holds: assert property (flash_req_o && !flash_done_i
    |=> flash_req_o && $stable(flash_addr_o)) else $error("request dropped early");
  a_done_ends: assert property (flash_req_o && flash_done_i |=> !flash_req_o &&
    !core_stall_o && flash_op_o == fari_pkg::FARI_OP_NONE) else $error("not idle");
  a_read_lands: assert property (flash_req_o && flash_done_i &&
    flash_op_o == fari_pkg::FARI_OP_READ |=> sfr_addr_i != 8'hBC ||
    sfr_rdata_o == $past(flash_rdata_i)) else $error("read byte lost");
  a_unmapped_zero: assert property (!sfr_hit_o |-> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_idle: assert property ($past(rst_i) |-> !flash_req_o &&
    flash_addr_o == 16'h0000) else $error("not idle after reset");
endmodule

// *** testbench/fari_array_model.sv ***
// behavioural flash array; low address bits pick the answer delay
`timescale 1ns/100ps
module fari_array_model (
  // request side
  input wire logic clk_i,
  input wire logic req_i,
  input wire fari_pkg::fari_op_t op_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  // answer side
  output logic [7:0] rdata_o,
  output logic done_o
);
  logic [7:0] mem [logic [15:0]];
  logic [1:0] cnt_r = 2'h0;
  initial done_o = 1'b0;
  initial rdata_o = 8'h00;
  // idle read bus toggles so a stale byte never passes for an answer
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    rdata_o <= ~rdata_o;
    cnt_r <= 2'h0;
    if (req_i && !done_o) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == addr_i[1:0]) begin
        done_o <= 1'b1;
        rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
        if (op_i == fari_pkg::FARI_OP_PROGRAM) mem[addr_i] = wdata_i;
        if (op_i == fari_pkg::FARI_OP_ERASE_ALL) mem.delete();
        if (op_i == fari_pkg::FARI_OP_ERASE_PAGE) begin
          foreach (mem[k]) if (k[15:9] == addr_i[15:9]) mem[k] = 8'hFF;
        end
      end
    end
  end
endmodule

// *** testbench/test_flash_access_register_interface.sv ***
// self-checking bench for the flash register front end
`timescale 1ns/100ps
module test_flash_access_register_interface;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [30:0] rd_prot_i = 31'h00000000;
  logic [7:0] stored_prot_key_i = 8'hFF;
  logic [7:0] sfr_rdata_o, flash_wdata_o, flash_rdata_i, last_wd;
  logic sfr_hit_o, core_stall_o, irq_defer_o, flash_req_o, flash_done_i;
  logic [15:0] flash_addr_o;
  logic [15:0] cur_a = 16'h0000;
  fari_pkg::fari_op_t flash_op_o;
  int errors = 0;
  int num_checks = 0;
  fari_flash_regs dut (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .sfr_hit_o, .core_stall_o, .irq_defer_o, .flash_req_o, .flash_op_o, .flash_addr_o,
    .flash_wdata_o, .flash_rdata_i, .flash_done_i, .rd_prot_i, .stored_prot_key_i);
  fari_array_model array (.clk_i, .req_i(flash_req_o), .op_i(flash_op_o),
    .addr_i(flash_addr_o), .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i),
    .done_o(flash_done_i));
  always #25 clk_i = ~clk_i;
  // the byte sent to the array is held only until the next command starts, so keep it
  always @(posedge clk_i) if (flash_req_o) last_wd <= flash_wdata_o;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #2;
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    #2;
    sfr_addr_i = a;
    #5;
    cmp(sfr_rdata_o, e);
  endtask
  task automatic ad(input logic [15:0] a);
    cur_a = a;
    wr(8'hC7, a[15:8]);
    wr(8'hC6, a[7:0]);
  endtask
  // command write; afterwards the data register stays addressed while busy
  task automatic cmd(input logic [7:0] c, input logic go);
    int n;
    n = 0;
    @(posedge clk_i);
    #2;
    sfr_addr_i = 8'hB9;
    sfr_wdata_i = c;
    sfr_wr_i = 1'b1;
    #5;
    cmp(8'(core_stall_o), 8'(go));
    cmp(8'(irq_defer_o), 8'(go));
    @(posedge clk_i);
    #2;
    sfr_wr_i = 1'b0;
    sfr_addr_i = 8'hBC;
    cmp(8'(flash_req_o), 8'(go));
    if (go) cmp(flash_addr_o[15:8], cur_a[15:8]);
    if (go) cmp(flash_addr_o[7:0], cur_a[7:0]);
    while (flash_req_o && n < 40) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    cmp(8'({core_stall_o, n < 40}), 8'h01);
  endtask
  task automatic kc(input logic [7:0] c, input logic go);
    wr(8'hBA, 8'h3B);
    cmd(c, go);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] a [7] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hC6, 8'hC7, 8'hC8};
    logic [7:0] v [7] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) rd(a[i], v[i]);
    cmp(8'(sfr_hit_o), 8'h00);
    $display("reset test over");
  endtask
  task automatic t_rw();
    wr(8'hBC, 8'hA5);
    ad(16'h3C03);
    kc(8'h01, 1'b1);
    rd(8'hBA, 8'hFF);
    wr(8'hBC, 8'h00);
    kc(8'h04, 1'b1);
    rd(8'hBC, 8'hA5);
    ad(16'h3C00);
    kc(8'h04, 1'b1);
    rd(8'hBC, 8'hFF);
    $display("program and read test over");
  endtask
  // refused commands: wrong key, reserved codes, page past the end, read protected group
  task automatic t_refuse();
    wr(8'hBA, 8'h55);
    cmd(8'h04, 1'b0);
    rd(8'hB9, 8'h04);
    for (int c = 5; c < 8; c++) kc(8'(c), 1'b0);
    ad(16'hF800);
    kc(8'h04, 1'b0);
    ad(16'h3C03);
    rd_prot_i[7] = 1'b1;
    kc(8'h04, 1'b0);
    rd_prot_i = 31'h00000040;
    rd(8'hBC, 8'hFF);
    kc(8'h04, 1'b1);
    rd(8'hBC, 8'hA5);
    $display("refusal test over");
  endtask
  task automatic t_erase();
    ad(16'hF600);
    kc(8'h04, 1'b1);
    ad(16'h3C03);
    kc(8'h02, 1'b1);
    kc(8'h04, 1'b1);
    rd(8'hBC, 8'hFF);
    wr(8'hBC, 8'h96);
    kc(8'h01, 1'b1);
    kc(8'h03, 1'b1);
    kc(8'h04, 1'b1);
    rd(8'hBC, 8'hFF);
    wr(8'hBB, 8'h5A);
    kc(8'h08, 1'b1);
    cmp(last_wd, 8'h5A);
    stored_prot_key_i = 8'h11;
    kc(8'h08, 1'b0);
    stored_prot_key_i = 8'h5A;
    kc(8'h08, 1'b1);
    $display("erase and protect test over");
  endtask
  // reset in mid run must return every register to its reset value
  task automatic t_again();
    wr(8'hBA, 8'h3B);
    @(posedge clk_i);
    #2;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    t_reset();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    t_reset();
    t_rw();
    t_refuse();
    t_erase();
    t_again();
    report_and_stop();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule
bind fari_flash_regs fari_flash_regs_props props (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .core_stall_o, .irq_defer_o, .flash_req_o,
  .flash_op_o, .flash_addr_o, .flash_rdata_i, .flash_done_i);
